// file: verilog/smae_regs.svh
// register map, field positions, reset values and timing counts of the match/ack engine
// assumes byte addressing on a 32-bit AHB-Lite bus, one word per register
// Function
// [RULE_01] match only when enable set; default on
// [RULE_02] filtered frames only; mode 2 short, 3 extended
// [RULE_03] 24-bit mask, extended hits set two bits
// [RULE_04] index 0x3F without source or match
// [RULE_05] index: lowest entry, type bit, pending bit
// [RULE_06] short: 24 entries, PAN and address equal
// [RULE_07] extended: 12 entries, 64-bit compare, 0x20
// [RULE_08] results stored as soon as available
// [RULE_09] append index instead of correlation if selected
// [RULE_10] found event just before done event
// [RULE_11] entry counts only if enabled throughout scan
// [RULE_12] auto check replaces FCS with status bytes
// [RULE_13] status carries FCS good bit
// [RULE_14] strength and correlation over first 8 symbols
// [RULE_15] ack only after good FCS; fixed format
// [RULE_16] ack sequence copied, ack FCS computed
// [RULE_17] pending bit is OR of three sources
// [RULE_18] ack right after reception, slotted selectable
// [RULE_19] strobes outside reception only raise event_a
// [RULE_20] last strobe wins; no-ack or bad FCS none
// [RULE_21] automatic ack conditions under filtering
// [RULE_22] automatic pending conditions; strobes override
// [RULE_23] address table at 0x380, 4n or 8n
// [RULE_24] extended enable odd bits read as even
// [RULE_25] ack frame control holds pending at standard bit
`ifndef SMAE_REGS_SVH
`define SMAE_REGS_SVH

`define SMAE_OFS_CTRL       10'h000
`define SMAE_OFS_SHORT_EN   10'h004
`define SMAE_OFS_EXT_EN     10'h008
`define SMAE_OFS_SHORT_PEND 10'h00c
`define SMAE_OFS_EXT_PEND   10'h010
`define SMAE_OFS_RES_MASK   10'h014
`define SMAE_OFS_RES_INDEX  10'h018
`define SMAE_OFS_STROBE     10'h01c
`define SMAE_OFS_STATUS     10'h020
`define SMAE_TBL_BASE       10'h380
`define SMAE_TBL_LAST       10'h3dc

`define SMAE_C_MATCH_EN     0
`define SMAE_C_AUTO_PEND    1
`define SMAE_C_DREQ_ONLY    2
`define SMAE_C_FILTER_EN    3
`define SMAE_C_AUTO_ACK     4
`define SMAE_C_AUTO_FCS     5
`define SMAE_C_APPEND_SEL   6
`define SMAE_C_PEND_OR      7
`define SMAE_C_SLOTTED      8
`define SMAE_CTRL_RST       9'h001

`define SMAE_S_ACK_NOW      0
`define SMAE_S_ACK_PEND     1
`define SMAE_S_NO_ACK       2

`define SMAE_IDX_NONE       7'h3f
`define SMAE_SHORT_LAST     5'h17
`define SMAE_EXT_LAST       5'h0b
`define SMAE_SYM_AVG        4'h8
`define SMAE_CRC_POLY       16'h8408
`define SMAE_ACK_FCF        16'h0002
`define SMAE_FCF_PEND       4
`define SMAE_ACK_LEN        8'h05
`define SMAE_FT_BEACON      3'h0
`define SMAE_FT_ACK         3'h2
`define SMAE_MODE_SHORT     2'h2
`define SMAE_MODE_EXT       2'h3

`endif

// file: verilog/smae_pkg.sv
// types shared by the source match / acknowledgement engine
// assumes widths of the 24-entry address table
package smae_pkg;

	typedef enum logic [1:0] {
		MS_IDLE = 2'b00,
		MS_SCAN = 2'b01,
		MS_RES  = 2'b10,
		MS_DONE = 2'b11
	} smae_mstate_t;

	typedef enum logic [1:0] {
		AS_NONE  = 2'b00,
		AS_ACK   = 2'b01,
		AS_PEND  = 2'b10,
		AS_NOACK = 2'b11
	} smae_astb_t;

	typedef struct packed {
		logic                hrdy;
		logic [31:0]         hrdata;
		logic                wr_pend;
		logic                rd_pend;
		logic                addr_ok;
		logic [9:0]          addr;
		logic [8:0]          ctrl;
		logic [23:0]         short_en;
		logic [11:0]         ext_en;
		logic [23:0]         short_pend;
		logic [11:0]         ext_pend;
		logic [23:0]         res_mask;
		logic [6:0]          res_index;
		logic [23:0][31:0]   table_mem;
		logic                rx_active;
		smae_mstate_t        mstate;
		logic                ext_mode;
		logic [4:0]          scan_n;
		logic [23:0]         cand;
		logic [23:0]         hit;
		logic [15:0]         src_panid;
		logic [63:0]         src_addr;
		logic                dreq_ok;
		logic                auto_pend;
		smae_astb_t          astb;
		logic                accepted;
		logic                ack_req;
		logic [2:0]          ftype;
		logic [15:0]         crc;
		logic [3:0]          sym_cnt;
		logic [9:0]          corr_sum;
		logic [10:0]         rssi_sum;
		logic                stat_valid;
		logic [7:0]          stat0;
		logic [7:0]          stat1;
		logic                found;
		logic                done;
		logic                usage;
		logic                ack_start;
		logic [7:0]          ack_len;
		logic [15:0]         ack_fcf;
		logic [7:0]          ack_seq;
		logic [15:0]         ack_fcs;
		logic                ack_slot;
	} smae_state_t;

endpackage

// file: verilog/smae_top.sv
// source address matching, status byte substitution and ack decision
// assumes receive logic on the same clock and an AHB-Lite master
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "smae_regs.svh"

module smae_top #(
	parameter int N_SHORT = 24,
	parameter int N_EXT   = 12
) (
	// clock and reset
	input  wire logic        CLK_IN,
	input  wire logic        RST_N_IN,
	// ahb-lite slave
	input  wire logic        HSEL_IN,
	input  wire logic [31:0] HADDR_IN,
	input  wire logic [1:0]  HTRANS_IN,
	input  wire logic        HWRITE_IN,
	input  wire logic [2:0]  HSIZE_IN,
	input  wire logic [31:0] HWDATA_IN,
	input  wire logic        HREADY_IN,
	output logic      [31:0] HRDATA_OUT,
	output logic             HREADYOUT_OUT,
	output logic             HRESP_OUT,
	// receive path
	input  wire logic        RX_START_IN,
	input  wire logic        RX_BYTE_VALID_IN,
	input  wire logic [7:0]  RX_BYTE_IN,
	input  wire logic        RX_SYM_VALID_IN,
	input  wire logic [7:0]  RX_SYM_RSSI_IN,
	input  wire logic [6:0]  RX_SYM_CORR_IN,
	input  wire logic        RX_ACCEPTED_IN,
	input  wire logic [1:0]  RX_SRC_MODE_IN,
	input  wire logic [15:0] RX_SRC_PANID_IN,
	input  wire logic [63:0] RX_SRC_ADDR_IN,
	input  wire logic        RX_ACK_REQ_IN,
	input  wire logic [2:0]  RX_FRAME_TYPE_IN,
	input  wire logic        RX_DATA_REQ_IN,
	input  wire logic [7:0]  RX_SEQ_IN,
	input  wire logic        RX_END_IN,
	// status bytes and events
	output logic             STAT_VALID_OUT,
	output logic      [7:0]  STAT_BYTE0_OUT,
	output logic      [7:0]  STAT_BYTE1_OUT,
	output logic             MATCH_FOUND_OUT,
	output logic             MATCH_DONE_OUT,
	output logic             EVENT_A_OUT,
	// acknowledgement request
	output logic             ACK_START_OUT,
	output logic      [7:0]  ACK_LEN_OUT,
	output logic      [15:0] ACK_FCF_OUT,
	output logic      [7:0]  ACK_SEQ_OUT,
	output logic      [15:0] ACK_FCS_OUT,
	output logic             ACK_SLOTTED_OUT
);

	if (N_SHORT != 24 || N_EXT * 2 != N_SHORT) begin : g_chk
		$error("smae_top: table must be 24 short / 12 extended entries");
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ `SMAE_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	smae_pkg::smae_state_t st_r;
	smae_pkg::smae_state_t st_nxt;
	logic [31:0] rdata;
	logic [9:0]  toff;
	logic [4:0]  tidx;
	logic [23:0] en_vec;
	logic [23:0] pend_vec;
	logic [23:0] fin;
	logic [23:0] ext_mask;
	logic [4:0]  low_idx;
	logic        fin_pend;
	logic        cmp_hit;
	logic        crc_ok;
	logic        auto_ack;
	logic        send;
	logic        pend;
	logic [15:0] fcf;
	logic [4:0]  n2;

	always_comb begin
		en_vec = st_r.ext_mode ? {12'h000, st_r.ext_en} : st_r.short_en;
		pend_vec = st_r.ext_mode ? {12'h000, st_r.ext_pend} : st_r.short_pend;
		// [RULE_11] enable rechecked at result
		fin = st_r.hit & st_r.cand & en_vec;
		// [RULE_03] extended hit sets pair
		ext_mask = 24'h000000;
		for (int i = 0; i < 12; i++) begin
			ext_mask[2 * i] = fin[i];
			ext_mask[2 * i + 1] = fin[i];
		end
		low_idx = 5'h00;
		for (int i = 23; i >= 0; i--) begin
			if (fin[i]) begin
				low_idx = 5'(i);
			end
		end
		// [RULE_22] automatic pending gate
		fin_pend = (|(fin & pend_vec)) && st_r.ctrl[`SMAE_C_AUTO_PEND]
			&& st_r.ctrl[`SMAE_C_FILTER_EN] && st_r.ctrl[`SMAE_C_MATCH_EN] && st_r.dreq_ok;
		n2 = {st_r.scan_n[3:0], 1'b0};
		// [RULE_06] pan and short compare
		// [RULE_07] full extended compare
		cmp_hit = st_r.ext_mode
			? ({st_r.table_mem[n2 + 5'h01], st_r.table_mem[n2]} == st_r.src_addr)
			: (st_r.table_mem[st_r.scan_n] == {st_r.src_addr[15:0], st_r.src_panid});
		crc_ok = (st_r.crc == 16'h0000);
		toff = st_r.addr - `SMAE_TBL_BASE;
		tidx = toff[6:2];
	end

	////////////////////////////////////////////////////////////////////////////////
	// register read mux
	always_comb begin
		rdata = 32'h00000000;
		if (st_r.addr_ok) begin
			unique case (st_r.addr)
				`SMAE_OFS_CTRL:       rdata = {23'h000000, st_r.ctrl};
				`SMAE_OFS_SHORT_EN:   rdata = {8'h00, st_r.short_en};
				`SMAE_OFS_SHORT_PEND: rdata = {8'h00, st_r.short_pend};
				`SMAE_OFS_RES_MASK:   rdata = {8'h00, st_r.res_mask};
				`SMAE_OFS_RES_INDEX:  rdata = {25'h0000000, st_r.res_index};
				`SMAE_OFS_STATUS:     rdata = {30'h00000000, st_r.mstate != smae_pkg::MS_IDLE,
					st_r.rx_active};
				`SMAE_OFS_EXT_EN, `SMAE_OFS_EXT_PEND: begin
					// [RULE_24] odd bits mirror even
					for (int i = 0; i < 12; i++) begin
						rdata[2 * i] = (st_r.addr == `SMAE_OFS_EXT_EN) ? st_r.ext_en[i]
							: st_r.ext_pend[i];
						rdata[2 * i + 1] = rdata[2 * i];
					end
				end
				default: begin
					// [RULE_23] table window
					if (st_r.addr >= `SMAE_TBL_BASE && st_r.addr <= `SMAE_TBL_LAST) begin
						rdata = st_r.table_mem[tidx];
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		st_nxt.found = 1'b0;
		st_nxt.done = 1'b0;
		st_nxt.usage = 1'b0;
		st_nxt.stat_valid = 1'b0;
		st_nxt.ack_start = 1'b0;
		send = 1'b0;
		pend = 1'b0;
		fcf = `SMAE_ACK_FCF;
		auto_ack = 1'b0;

		// bus write data phase
		if (st_r.wr_pend && st_r.addr_ok) begin
			unique case (st_r.addr)
				`SMAE_OFS_CTRL:       st_nxt.ctrl = HWDATA_IN[8:0];
				`SMAE_OFS_SHORT_EN:   st_nxt.short_en = HWDATA_IN[23:0];
				`SMAE_OFS_SHORT_PEND: st_nxt.short_pend = HWDATA_IN[23:0];
				`SMAE_OFS_EXT_EN: begin
					for (int i = 0; i < 12; i++) begin
						st_nxt.ext_en[i] = HWDATA_IN[2 * i];
					end
				end
				`SMAE_OFS_EXT_PEND: begin
					for (int i = 0; i < 12; i++) begin
						st_nxt.ext_pend[i] = HWDATA_IN[2 * i];
					end
				end
				`SMAE_OFS_STROBE: begin
					if (HWDATA_IN[2:0] != 3'h0) begin
						// [RULE_19] strobe only during reception
						if (!st_r.rx_active) begin
							st_nxt.usage = 1'b1;
						// [RULE_20] later strobe replaces earlier
						end else if (HWDATA_IN[`SMAE_S_NO_ACK]) begin
							st_nxt.astb = smae_pkg::AS_NOACK;
						end else if (HWDATA_IN[`SMAE_S_ACK_PEND]) begin
							st_nxt.astb = smae_pkg::AS_PEND;
						end else begin
							st_nxt.astb = smae_pkg::AS_ACK;
						end
					end
				end
				default: begin
					if (st_r.addr >= `SMAE_TBL_BASE && st_r.addr <= `SMAE_TBL_LAST) begin
						st_nxt.table_mem[tidx] = HWDATA_IN;
					end
				end
			endcase
		end
		st_nxt.wr_pend = 1'b0;
		if (st_r.rd_pend) begin
			st_nxt.hrdata = rdata;
			st_nxt.hrdy = 1'b1;
			st_nxt.rd_pend = 1'b0;
		end
		if (HSEL_IN && HTRANS_IN[1] && HREADY_IN) begin
			st_nxt.addr = HADDR_IN[9:0];
			st_nxt.addr_ok = (HADDR_IN[31:10] == 22'h000000);
			if (HWRITE_IN) begin
				st_nxt.wr_pend = 1'b1;
			end else begin
				st_nxt.rd_pend = 1'b1;
				st_nxt.hrdy = 1'b0;
			end
		end

		// receive tracking
		if (RX_START_IN) begin
			st_nxt.rx_active = 1'b1;
			st_nxt.astb = smae_pkg::AS_NONE;
			st_nxt.crc = 16'h0000;
			st_nxt.sym_cnt = 4'h0;
			st_nxt.corr_sum = 10'h000;
			st_nxt.rssi_sum = 11'h000;
			st_nxt.accepted = 1'b0;
			st_nxt.auto_pend = 1'b0;
		end
		// [RULE_12] running FCS check
		if (st_r.rx_active && RX_BYTE_VALID_IN) begin
			st_nxt.crc = crc_byte(st_r.crc, RX_BYTE_IN);
		end
		// [RULE_14] first eight symbols summed
		if (st_r.rx_active && RX_SYM_VALID_IN && st_r.sym_cnt < `SMAE_SYM_AVG) begin
			st_nxt.sym_cnt = st_r.sym_cnt + 4'h1;
			st_nxt.corr_sum = st_r.corr_sum + {3'h0, RX_SYM_CORR_IN};
			st_nxt.rssi_sum = st_r.rssi_sum + {{3{RX_SYM_RSSI_IN[7]}}, RX_SYM_RSSI_IN};
		end
		if (RX_ACCEPTED_IN) begin
			st_nxt.accepted = 1'b1;
			st_nxt.ack_req = RX_ACK_REQ_IN;
			st_nxt.ftype = RX_FRAME_TYPE_IN;
			st_nxt.dreq_ok = !st_r.ctrl[`SMAE_C_DREQ_ONLY] || RX_DATA_REQ_IN;
			// [RULE_01] matching gated by enable
			// [RULE_02] filtered frames, mode picks algorithm
			if (st_r.ctrl[`SMAE_C_MATCH_EN] && st_r.ctrl[`SMAE_C_FILTER_EN]) begin
				st_nxt.src_panid = RX_SRC_PANID_IN;
				st_nxt.src_addr = RX_SRC_ADDR_IN;
				st_nxt.hit = 24'h000000;
				st_nxt.scan_n = 5'h00;
				if (RX_SRC_MODE_IN == `SMAE_MODE_SHORT || RX_SRC_MODE_IN == `SMAE_MODE_EXT) begin
					st_nxt.ext_mode = (RX_SRC_MODE_IN == `SMAE_MODE_EXT);
					st_nxt.cand = (RX_SRC_MODE_IN == `SMAE_MODE_EXT)
						? {12'h000, st_r.ext_en} : st_r.short_en;
					st_nxt.mstate = smae_pkg::MS_SCAN;
				end else begin
					// [RULE_04] no source address
					st_nxt.res_mask = 24'h000000;
					st_nxt.res_index = `SMAE_IDX_NONE;
					st_nxt.done = 1'b1;
					st_nxt.mstate = smae_pkg::MS_IDLE;
				end
			end
		end

		// match sequencer
		unique case (st_r.mstate)
			smae_pkg::MS_IDLE: begin
			end
			smae_pkg::MS_SCAN: begin
				// [RULE_11] candidate dropped once disabled
				st_nxt.cand[st_r.scan_n] = st_r.cand[st_r.scan_n] & en_vec[st_r.scan_n];
				st_nxt.hit[st_r.scan_n] = cmp_hit;
				if (st_r.scan_n == (st_r.ext_mode ? `SMAE_EXT_LAST : `SMAE_SHORT_LAST)) begin
					st_nxt.mstate = smae_pkg::MS_RES;
				end else begin
					st_nxt.scan_n = st_r.scan_n + 5'h01;
				end
			end
			smae_pkg::MS_RES: begin
				// [RULE_08] results stored at once
				st_nxt.res_mask = st_r.ext_mode ? ext_mask : fin;
				st_nxt.auto_pend = (|fin) && fin_pend;
				if (|fin) begin
					// [RULE_05] index layout
					st_nxt.res_index = {fin_pend, st_r.ext_mode, low_idx};
					// [RULE_10] found precedes done
					st_nxt.found = 1'b1;
					st_nxt.mstate = smae_pkg::MS_DONE;
				end else begin
					st_nxt.res_index = `SMAE_IDX_NONE;
					st_nxt.done = 1'b1;
					st_nxt.mstate = smae_pkg::MS_IDLE;
				end
			end
			smae_pkg::MS_DONE: begin
				st_nxt.done = 1'b1;
				st_nxt.mstate = smae_pkg::MS_IDLE;
			end
		endcase

		// frame end: status bytes and ack decision
		if (st_r.rx_active && RX_END_IN) begin
			st_nxt.rx_active = 1'b0;
			if (st_r.ctrl[`SMAE_C_AUTO_FCS]) begin
				// [RULE_12] status replaces FCS
				st_nxt.stat_valid = 1'b1;
				st_nxt.stat0 = st_r.rssi_sum[10:3];
				// [RULE_13] good bit in status
				// [RULE_09] index replaces correlation
				st_nxt.stat1 = {crc_ok, st_r.ctrl[`SMAE_C_APPEND_SEL] ? st_r.res_index
					: st_r.corr_sum[9:3]};
			end
			// [RULE_21] automatic ack conditions
			auto_ack = st_r.ctrl[`SMAE_C_FILTER_EN] && st_r.ctrl[`SMAE_C_AUTO_ACK]
				&& st_r.accepted && st_r.ack_req && st_r.ftype != `SMAE_FT_BEACON
				&& st_r.ftype != `SMAE_FT_ACK;
			// [RULE_17] pending sources ORed
			pend = st_r.ctrl[`SMAE_C_PEND_OR] || st_r.auto_pend;
			// [RULE_20] last strobe decides
			unique case (st_nxt.astb)
				smae_pkg::AS_NONE:  send = auto_ack;
				smae_pkg::AS_ACK:   send = 1'b1;
				smae_pkg::AS_PEND: begin
					send = 1'b1;
					pend = 1'b1;
				end
				smae_pkg::AS_NOACK: send = 1'b0;
			endcase
			// [RULE_15] good FCS required
			// [RULE_18] ack only at reception end
			if (send && crc_ok) begin
				// [RULE_25] pending at frame control bit 4
				fcf[`SMAE_FCF_PEND] = pend;
				st_nxt.ack_start = 1'b1;
				st_nxt.ack_len = `SMAE_ACK_LEN;
				st_nxt.ack_fcf = fcf;
				// [RULE_16] copied sequence, computed FCS
				st_nxt.ack_seq = RX_SEQ_IN;
				st_nxt.ack_fcs = crc_byte(crc_byte(crc_byte(16'h0000, fcf[7:0]), fcf[15:8]),
					RX_SEQ_IN);
				st_nxt.ack_slot = st_r.ctrl[`SMAE_C_SLOTTED];
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			st_r <= '0;
			st_r.hrdy <= 1'b1;
			st_r.ctrl <= `SMAE_CTRL_RST;
			st_r.res_index <= `SMAE_IDX_NONE;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign HRDATA_OUT = st_r.hrdata;
	assign HREADYOUT_OUT = st_r.hrdy;
	assign HRESP_OUT = 1'b0;
	assign STAT_VALID_OUT = st_r.stat_valid;
	assign STAT_BYTE0_OUT = st_r.stat0;
	assign STAT_BYTE1_OUT = st_r.stat1;
	assign MATCH_FOUND_OUT = st_r.found;
	assign MATCH_DONE_OUT = st_r.done;
	assign EVENT_A_OUT = st_r.usage;
	assign ACK_START_OUT = st_r.ack_start;
	assign ACK_LEN_OUT = st_r.ack_len;
	assign ACK_FCF_OUT = st_r.ack_fcf;
	assign ACK_SEQ_OUT = st_r.ack_seq;
	assign ACK_FCS_OUT = st_r.ack_fcs;
	assign ACK_SLOTTED_OUT = st_r.ack_slot;

	////////////////////////////////////////////////////////////////////////////////
	property p_found_then_done;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		MATCH_FOUND_OUT |=> MATCH_DONE_OUT && !MATCH_FOUND_OUT;
	endproperty
	a_found_then_done: assert property (p_found_then_done) else $error("done missing"); // [RULE_10]

	property p_no_match_index;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		MATCH_DONE_OUT && !$past(MATCH_FOUND_OUT) |-> st_r.res_index == `SMAE_IDX_NONE;
	endproperty
	a_no_match_index: assert property (p_no_match_index) else $error("bad none index"); // [RULE_04]

	property p_type_bit;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		MATCH_FOUND_OUT |-> st_r.res_index[5] == st_r.ext_mode
			&& st_r.res_index[4:0] <= `SMAE_SHORT_LAST;
	endproperty
	a_type_bit: assert property (p_type_bit) else $error("index type bit wrong"); // [RULE_05]

	property p_pair_mask;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		MATCH_DONE_OUT && st_r.ext_mode |-> (st_r.res_mask[22:0] & 24'h555555) ==
			((st_r.res_mask >> 1) & 24'h555555);
	endproperty
	a_pair_mask: assert property (p_pair_mask) else $error("mask pair broken"); // [RULE_03]

	property p_match_disabled;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		RX_ACCEPTED_IN && !st_r.ctrl[`SMAE_C_MATCH_EN] && st_r.mstate == smae_pkg::MS_IDLE
			|=> !MATCH_DONE_OUT;
	endproperty
	a_match_disabled: assert property (p_match_disabled) else $error("match while off"); // [RULE_01]

	property p_ack_needs_fcs;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		ACK_START_OUT |-> $past(st_r.crc) == 16'h0000 && $past(RX_END_IN);
	endproperty
	a_ack_needs_fcs: assert property (p_ack_needs_fcs) else $error("ack after bad FCS"); // [RULE_15]

	property p_usage;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		st_r.wr_pend && st_r.addr_ok && st_r.addr == `SMAE_OFS_STROBE && HWDATA_IN[2:0] != 3'h0
			&& !st_r.rx_active |=> EVENT_A_OUT ##1 !EVENT_A_OUT;
	endproperty
	a_usage: assert property (p_usage) else $error("usage event missing"); // [RULE_19]

	property p_fcf;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		ACK_START_OUT |-> (ACK_FCF_OUT & 16'hffef) == `SMAE_ACK_FCF && ACK_LEN_OUT == `SMAE_ACK_LEN;
	endproperty
	a_fcf: assert property (p_fcf) else $error("ack frame control wrong"); // [RULE_25]

	property p_noack;
		@(posedge CLK_IN) disable iff (!RST_N_IN)
		st_r.rx_active && RX_END_IN && st_r.astb == smae_pkg::AS_NOACK && !st_r.wr_pend
			|=> !ACK_START_OUT;
	endproperty
	a_noack: assert property (p_noack) else $error("ack despite no-ack"); // [RULE_20]

endmodule

// file: sim/smae_rx_model.sv
// receive-side partner: start, symbols, bytes with fcs, accept and end pulses
// assumes the engine clock; every field changes just after a rising edge
`timescale 1ns/1ps

module smae_rx_model (
	// clock
	input  wire logic   clk_in,
	// receive path
	output logic        start_out, bv_out, sv_out, acc_out, areq_out, dreq_out, end_out,
	output logic [7:0]  byte_out, rssi_out, seq_out,
	output logic [6:0]  corr_out,
	output logic [1:0]  mode_out,
	output logic [15:0] pan_out,
	output logic [63:0] addr_out,
	output logic [2:0]  ft_out
);
	initial {start_out, bv_out, sv_out, acc_out, areq_out, dreq_out, end_out, byte_out,
		rssi_out, seq_out, corr_out, mode_out, pan_out, addr_out, ft_out} = '0;

	// reflected crc step, lsb first
	function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] b);
		for (int k = 0; k < 8; k++)
			c = (c[0] ^ b[k]) ? (c >> 1) ^ 16'h8408 : c >> 1;
		return c;
	endfunction

	task automatic head(input logic [1:0] m, input logic [15:0] p, input logic [63:0] a,
		input logic bad);
		logic [15:0] c;
		logic [7:0]  d [5];
		c = 16'h0000;
		d = '{8'h41, 8'h42, 8'h43, 8'h00, 8'h00};
		for (int i = 0; i < 3; i++)
			c = crc_add(c, d[i]);
		d[3] = c[7:0] ^ {7'h00, bad};
		d[4] = c[15:8];
		@(posedge clk_in) start_out <= 1'b1;
		@(posedge clk_in) start_out <= 1'b0;
		repeat (8) begin
			@(posedge clk_in) {sv_out, rssi_out, corr_out} <= {1'b1, 8'hd0, 7'h50};
			@(posedge clk_in) {sv_out, rssi_out, corr_out} <= {1'b0, 8'h2f, 7'h2f};
		end
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_in) {bv_out, byte_out} <= {1'b1, d[i]};
			@(posedge clk_in) {bv_out, byte_out} <= {1'b0, ~d[i]};
		end
		@(posedge clk_in) {acc_out, mode_out, pan_out, addr_out, areq_out, ft_out}
			<= {1'b1, m, p, a, 1'b1, 3'h1};
		@(posedge clk_in) {acc_out, mode_out, pan_out, addr_out} <= {1'b0, ~m, ~p, ~a};
	endtask

	task automatic tail(input logic [7:0] s);
		@(posedge clk_in) {end_out, seq_out} <= {1'b1, s};
		@(posedge clk_in) {end_out, seq_out} <= {1'b0, ~s};
	endtask
endmodule

// file: sim/tb.sv
// testbench of the match/ack engine: register bus, matching, status, ack
// assumes the partner model drives the receive path
`timescale 1ns/1ps
`include "smae_regs.svh"

module tb;
	logic        clk, rst_n, hwrite, hrdy, hresp;
	logic [1:0]  htrans, mode;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic        st, bv, sv, acc, areq, dreq, rend, svld, fnd, dne, eva, ack, slot;
	logic [7:0]  rb, rssi, seq, s0, s1, alen, aseq;
	logic [6:0]  corr;
	logic [15:0] pan, fcf, fcs, c;
	logic [63:0] addr;
	logic [2:0]  ft;
	int          failures, checks_done, n_fnd, n_dne, n_eva, n_ack;
	realtime     tf, td;

	smae_rx_model smae_rx_model_inst (.clk_in(clk), .start_out(st), .bv_out(bv),
		.sv_out(sv), .acc_out(acc), .areq_out(areq), .dreq_out(dreq), .end_out(rend),
		.byte_out(rb), .rssi_out(rssi), .seq_out(seq), .corr_out(corr), .mode_out(mode),
		.pan_out(pan), .addr_out(addr), .ft_out(ft));

	smae_top smae_top_inst (.CLK_IN(clk), .RST_N_IN(rst_n), .HSEL_IN(1'b1),
		.HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
		.HWDATA_IN(hwdata), .HREADY_IN(hrdy), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy),
		.HRESP_OUT(hresp), .RX_START_IN(st), .RX_BYTE_VALID_IN(bv), .RX_BYTE_IN(rb),
		.RX_SYM_VALID_IN(sv), .RX_SYM_RSSI_IN(rssi), .RX_SYM_CORR_IN(corr),
		.RX_ACCEPTED_IN(acc), .RX_SRC_MODE_IN(mode), .RX_SRC_PANID_IN(pan),
		.RX_SRC_ADDR_IN(addr), .RX_ACK_REQ_IN(areq), .RX_FRAME_TYPE_IN(ft),
		.RX_DATA_REQ_IN(dreq), .RX_SEQ_IN(seq), .RX_END_IN(rend), .STAT_VALID_OUT(svld),
		.STAT_BYTE0_OUT(s0), .STAT_BYTE1_OUT(s1), .MATCH_FOUND_OUT(fnd),
		.MATCH_DONE_OUT(dne), .EVENT_A_OUT(eva), .ACK_START_OUT(ack), .ACK_LEN_OUT(alen),
		.ACK_FCF_OUT(fcf), .ACK_SEQ_OUT(aseq), .ACK_FCS_OUT(fcs), .ACK_SLOTTED_OUT(slot));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// pulse counters and event times
	always @(posedge clk) begin
		n_fnd <= n_fnd + int'(fnd === 1'b1);
		n_dne <= n_dne + int'(dne === 1'b1);
		n_eva <= n_eva + int'(eva === 1'b1);
		n_ack <= n_ack + int'(ack === 1'b1);
		if (fnd === 1'b1)
			tf = $realtime;
		if (dne === 1'b1)
			td = $realtime;
	end

	task automatic cmp(input logic [31:0] got, exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one single ahb-lite transfer, address then data phase
	task automatic xfer(input logic w, input logic [31:0] a, d);
		@(posedge clk) {htrans, haddr, hwrite} <= {2'h2, a, w};
		do @(posedge clk); while (hrdy !== 1'b1);
		{htrans, hwdata} <= {2'h0, d};
		do @(posedge clk); while (hrdy !== 1'b1);
		r = hrdata;
	endtask

	task automatic wr(input logic [31:0] a, d);
		xfer(1'b1, a, d);
	endtask

	task automatic chk(input logic [31:0] a, exp);
		xfer(1'b0, a, 32'h0);
		cmp(r, exp);
	endtask

	task automatic results;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic s_reset;
		chk(32'(`SMAE_OFS_CTRL), 32'h1);
		chk(32'(`SMAE_OFS_RES_INDEX), 32'h3f);
		chk(32'h200, 32'h0);
		wr(32'(`SMAE_OFS_EXT_EN), 32'h4);
		chk(32'(`SMAE_OFS_EXT_EN), 32'hc);
	endtask

	task automatic s_short;
		wr(32'h38c, 32'hbeef1234);
		wr(32'h394, 32'hbeef1234);
		wr(32'h3a4, 32'hbeef1234);
		wr(32'(`SMAE_OFS_SHORT_EN), 32'h220);
		wr(32'(`SMAE_OFS_EXT_EN), 32'h0);
		wr(32'(`SMAE_OFS_CTRL), 32'h39);
		smae_rx_model_inst.head(2'h2, 16'h1234, 64'hbeef, 1'b0);
		repeat (30) @(posedge clk);
		chk(32'(`SMAE_OFS_RES_MASK), 32'h220);
		chk(32'(`SMAE_OFS_RES_INDEX), 32'h05);
		cmp(32'(int'(td - tf)), 32'd5);
		smae_rx_model_inst.tail(8'h11);
		repeat (2) @(posedge clk);
		cmp({n_fnd[7:0], n_dne[7:0], n_ack[7:0]}, 32'h010101);
		cmp({fcf, s0, s1}, 32'h0002d0d0);
		cmp({30'h0, hresp, slot}, 32'h0);
	endtask

	task automatic s_ext;
		wr(32'h398, 32'h05060708);
		wr(32'h39c, 32'h01020304);
		wr(32'(`SMAE_OFS_SHORT_EN), 32'h0);
		wr(32'(`SMAE_OFS_EXT_EN), 32'h40);
		wr(32'(`SMAE_OFS_CTRL), 32'h169);
		smae_rx_model_inst.head(2'h3, 16'hffff, 64'h0102030405060708, 1'b0);
		wr(32'(`SMAE_OFS_STROBE), 32'h2);
		repeat (30) @(posedge clk);
		chk(32'(`SMAE_OFS_RES_MASK), 32'hc0);
		chk(32'(`SMAE_OFS_RES_INDEX), 32'h23);
		smae_rx_model_inst.tail(8'h5a);
		repeat (2) @(posedge clk);
		c = smae_rx_model_inst.crc_add(16'h0, 8'h12);
		c = smae_rx_model_inst.crc_add(smae_rx_model_inst.crc_add(c, 8'h00), 8'h5a);
		cmp({fcf, aseq, s1}, 32'h00125aa3);
		cmp({alen, 8'(n_ack), fcs}, {16'h0502, c});
		cmp({30'h0, hresp, slot}, 32'h1);
	endtask

	task automatic s_err;
		wr(32'(`SMAE_OFS_STROBE), 32'h1);
		repeat (2) @(posedge clk);
		cmp(32'(n_eva), 32'd1);
		smae_rx_model_inst.head(2'h0, 16'h0, 64'h0, 1'b1);
		wr(32'(`SMAE_OFS_STROBE), 32'h1);
		repeat (30) @(posedge clk);
		smae_rx_model_inst.tail(8'h22);
		repeat (2) @(posedge clk);
		cmp({8'(n_fnd), 8'(n_dne), 8'(n_ack), s1}, 32'h0203023f);
	endtask

	initial begin
		{rst_n, htrans, hwrite, haddr, hwdata} = '0;
		{failures, checks_done, n_fnd, n_dne, n_eva, n_ack} = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		s_reset();
		s_short();
		s_ext();
		s_err();
		results();
	end

	initial begin
		#20000;
		failures++;
		results();
	end
endmodule
